/* design/arf_pkg.sv */
package arf_pkg;

   // register offsets on the plain register port
   localparam logic [2:0] OFS_CONTROL   = 3'h0;
   localparam logic [2:0] OFS_CONFIG    = 3'h1;
   localparam logic [2:0] OFS_RES_HIGH  = 3'h2;
   localparam logic [2:0] OFS_RES_LOW   = 3'h3;
   localparam logic [2:0] OFS_IRQ_STAT  = 3'h4;
   localparam logic [2:0] OFS_IRQ_MASK  = 3'h5;

   // conversion_control fields
   localparam int          POS_ENABLE    = 0;
   localparam int          POS_BUSY      = 1;
   localparam int          POS_CHAN_LSB  = 2;
   localparam logic [7:0]  CONTROL_WMASK = 8'h7f;
   localparam logic [7:0]  CONTROL_RST   = 8'h00;

   // conversion_config fields
   localparam int          POS_FORMAT    = 7;
   localparam logic [7:0]  CONFIG_WMASK  = 8'hf7;
   localparam logic [7:0]  CONFIG_RST    = 8'h00;

   // interrupt status bit layout
   localparam int          POS_IRQ_DONE  = 0;
   localparam logic [7:0]  IRQ_WMASK     = 8'h01;
   localparam logic [7:0]  IRQ_RST       = 8'h00;

   localparam int          CODE_WIDTH    = 10;
   localparam int          CODE_STEPS    = 1024;

   // conversion time: printed in ns, converted to cycles
   localparam int          CLK_PERIOD_NS = 100;
   localparam int          CONV_TIME_NS  = 2200;
   localparam int          CONV_CYCLES   =
      (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0]  CONV_LAST     = 5'(CONV_CYCLES - 1);

   typedef enum logic [0:0] {
      ARF_IDLE = 1'b0,
      ARF_CONV = 1'b1
   } arf_state_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } arf_bus_t;

   typedef struct packed {
      arf_state_t state;
      logic [4:0] count;
      logic [7:0] control;
      logic [7:0] config_r;
      logic [7:0] res_high;
      logic [7:0] res_low;
      logic [7:0] irq_stat;
      logic [7:0] irq_mask;
      logic [7:0] rdata;
   } arf_regs_t;

endpackage

/* design/arf_result_formatter.sv */
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: left format: code 9..2 fill high register
// RULE_02: left format: code 1..0 in low bits 7..6
// RULE_03: right format: code 9..8 in high bits 1..0
// RULE_04: right format: code 7..0 fill low register
// RULE_05: result registers writable; kept over soft reset
// RULE_06: code is 10-bit unsigned, 1024 steps
// RULE_07: software waits acquisition time after channel change
// RULE_08: unused result bits forced zero on load
// RULE_09: busy flag starts conversion, hardware clears it
// RULE_10: both results load as busy clears; an abort or a refused start clears busy without loading them
module arf_result_formatter
   import arf_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_soft_rst,
   // register port
   input  wire arf_bus_t          i_bus,
   output logic      [7:0]        o_rdata,
   // converter core
   input  wire logic [CODE_WIDTH-1:0] i_code,
   output logic                   o_enable,
   output logic      [4:0]        o_channel,
   output logic                   o_sampling,
   // interrupt
   output logic                   o_irq
);

   arf_regs_t q;
   arf_regs_t next_q;
   logic      done;
   logic [7:0] next_high;
   logic [7:0] next_low;
   logic [7:0] clr_mask;

   always_comb begin
      next_q   = q;
      done     = 1'b0;
      clr_mask = 8'h00;
      // code held as 10-bit unsigned, 0 .. CODE_STEPS-1
      if (q.config_r[POS_FORMAT]) begin // RULE_06
         next_high = {6'h00, i_code[9:8]}; // RULE_03 RULE_08
         next_low  = i_code[7:0]; // RULE_04
      end else begin
         next_high = i_code[9:2]; // RULE_01
         next_low  = {i_code[1:0], 6'h00}; // RULE_02 RULE_08
      end

      // register writes
      if (i_bus.wr) begin
         case (i_bus.addr)
            OFS_CONTROL:  next_q.control  = i_bus.wdata & CONTROL_WMASK;
            OFS_CONFIG:   next_q.config_r = i_bus.wdata & CONFIG_WMASK;
            OFS_RES_HIGH: next_q.res_high = i_bus.wdata; // RULE_05
            OFS_RES_LOW:  next_q.res_low  = i_bus.wdata; // RULE_05
            OFS_IRQ_MASK: next_q.irq_mask = i_bus.wdata & IRQ_WMASK;
            default: ;
         endcase
      end

      // conversion sequencer
      case (q.state)
         ARF_IDLE: begin
            next_q.count = 5'h00;
            if (next_q.control[POS_BUSY]) begin // RULE_09
               if (next_q.control[POS_ENABLE]) begin
                  next_q.state = ARF_CONV;
               end else begin
                  next_q.control[POS_BUSY] = 1'b0;
               end
            end
         end
         ARF_CONV: begin
            if (!next_q.control[POS_BUSY] ||
                !next_q.control[POS_ENABLE]) begin
               // aborted: result left untouched
               next_q.state = ARF_IDLE;
               next_q.control[POS_BUSY] = 1'b0;
            end else if (q.count == CONV_LAST) begin
               done = 1'b1;
               next_q.state = ARF_IDLE;
               next_q.control[POS_BUSY] = 1'b0; // RULE_09 RULE_10
               next_q.res_high = next_high; // RULE_10
               next_q.res_low  = next_low; // RULE_10
            end else begin
               next_q.count = q.count + 5'h01;
            end
         end
         default: next_q.state = ARF_IDLE;
      endcase

      // read data one cycle later; status cleared by its read
      next_q.rdata = 8'h00;
      if (i_bus.rd) begin
         case (i_bus.addr)
            OFS_CONTROL:  next_q.rdata = q.control;
            OFS_CONFIG:   next_q.rdata = q.config_r;
            OFS_RES_HIGH: next_q.rdata = q.res_high;
            OFS_RES_LOW:  next_q.rdata = q.res_low;
            OFS_IRQ_STAT: begin
               next_q.rdata = q.irq_stat;
               clr_mask     = q.irq_stat;
            end
            OFS_IRQ_MASK: next_q.rdata = q.irq_mask;
            default:      next_q.rdata = 8'h00;
         endcase
      end
      // set wins over read clear
      next_q.irq_stat = (q.irq_stat & ~clr_mask) |
                        ({7'h00, done} << POS_IRQ_DONE);

      // soft reset: control state cleared, results kept
      if (i_soft_rst) begin
         next_q.state    = ARF_IDLE;
         next_q.count    = 5'h00;
         next_q.control  = CONTROL_RST;
         next_q.config_r = CONFIG_RST;
         next_q.irq_stat = IRQ_RST;
         next_q.irq_mask = IRQ_RST;
         next_q.res_high = q.res_high; // RULE_05
         next_q.res_low  = q.res_low; // RULE_05
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '{state: ARF_IDLE, count: 5'h00, control: CONTROL_RST,
                config_r: CONFIG_RST, res_high: 8'h00, res_low: 8'h00,
                irq_stat: IRQ_RST, irq_mask: IRQ_RST, rdata: 8'h00};
      end else begin
         q <= next_q;
      end
   end

   // acquisition wait after channel change is up to software
   assign o_channel  = q.control[6:POS_CHAN_LSB]; // RULE_07
   assign o_enable   = q.control[POS_ENABLE];
   assign o_sampling = q.control[POS_ENABLE] && (q.state == ARF_IDLE);
   assign o_rdata    = q.rdata;
   assign o_irq      = |(q.irq_stat & q.irq_mask);

endmodule

/* sim/arf_monitor.sv */
`timescale 1ns/1ps
module arf_monitor
   import arf_pkg::*;
(
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_soft_rst,
   input wire arf_bus_t   i_bus,
   input wire logic [7:0] o_rdata,
   input wire logic [9:0] i_code,
   input wire logic       o_enable,
   input wire logic [4:0] o_channel,
   input wire logic       o_sampling,
   input wire logic       o_irq
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   idle_rdata_a: assert property (
      !$past(i_bus.rd) |-> o_rdata == 8'h00) else $error("stray data");
   unmapped_rd_a: assert property (
      $past(i_bus.rd && i_bus.addr > OFS_IRQ_MASK) |-> o_rdata == 8'h00)
      else $error("unmapped data");
   enable_wr_a: assert property (
      $past(i_bus.wr && i_bus.addr == OFS_CONTROL && !i_soft_rst)
      |-> o_enable == $past(i_bus.wdata[0])) else $error("enable bad");
   channel_wr_a: assert property (
      $past(i_bus.wr && i_bus.addr == OFS_CONTROL && !i_soft_rst)
      |-> o_channel == $past(i_bus.wdata[6:2])) else $error("chan bad");
   sample_en_a: assert property (
      o_sampling |-> o_enable) else $error("sampling while off");
   busy_start_a: assert property (
      $past(i_bus.wr && i_bus.addr == OFS_CONTROL && !i_soft_rst
      && i_bus.wdata[1:0] == 2'b11) |-> !o_sampling [*8])
      else $error("no conversion");
   mask_off_a: assert property (
      $past(i_bus.wr && i_bus.addr == OFS_IRQ_MASK && !i_bus.wdata[0])
      |-> !o_irq) else $error("masked irq");
   reset_out_a: assert property (
      $past(i_rst || i_soft_rst) |-> !o_enable && !o_irq)
      else $error("reset outputs");
endmodule
bind arf_result_formatter arf_monitor mon (.i_clk(i_clk),
   .i_rst(i_rst), .i_soft_rst(i_soft_rst), .i_bus(i_bus),
   .o_rdata(o_rdata), .i_code(i_code), .o_enable(o_enable),
   .o_channel(o_channel), .o_sampling(o_sampling), .o_irq(o_irq));

/* sim/arf_result_formatter_bench.sv */
`timescale 1ns/1ps
module arf_result_formatter_bench;
   import arf_pkg::*;
   logic       i_clk, i_rst, i_soft_rst, o_enable, o_sampling, o_irq;
   arf_bus_t   i_bus;
   logic [7:0] o_rdata, hi;
   logic [4:0] o_channel;
   logic [9:0] i_code, code;
   logic [15:0] res;
   int         n_errors, num_checks, seed, k, w;
   arf_result_formatter uut (.i_clk(i_clk), .i_rst(i_rst),
      .i_soft_rst(i_soft_rst), .i_bus(i_bus), .o_rdata(o_rdata),
      .i_code(i_code), .o_enable(o_enable), .o_channel(o_channel),
      .o_sampling(o_sampling), .o_irq(o_irq));
   function automatic logic [15:0] expect_res(logic f, logic [9:0] c);
      return f ? {6'h00, c} : {c, 6'h00};
   endfunction
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk) i_bus <= '{a, d, 1'b1, 1'b0};
      @(posedge i_clk) i_bus <= '0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge i_clk) i_bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge i_clk) i_bus <= '0;
      #1 check(o_rdata, e);
   endtask
   task automatic print_verdict;
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // hang guard, far beyond the planned run
   initial begin
      #5000000;
      n_errors++;
      print_verdict();
   end
   initial begin
      seed = 32'ha5c05ff7;
      {i_rst, i_soft_rst, i_bus, i_code} = '0;
      i_rst = 1'b1;
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      for (k = 0; k < 8; k++) rd(3'(k), 8'h00);
      for (k = 0; k < 12; k++) begin
         hi = 8'($random(seed));
         wr(OFS_RES_HIGH, hi);
         wr(OFS_RES_LOW, ~hi);
         rd(OFS_RES_HIGH, hi);
         rd(OFS_RES_LOW, ~hi);
         // corner codes first, then random ones
         code = (k < 4) ? {10{k[1]}} : 10'($random(seed));
         i_code <= code;
         wr(OFS_CONFIG, {k[0], 7'h00});
         wr(OFS_IRQ_MASK, 8'h01);
         wr(OFS_CONTROL, {1'b0, 5'(k), 2'b11});
         for (w = 0; w < 40 && o_irq !== 1'b1; w++) @(posedge i_clk);
         check(o_irq, 1'b1);
         check(o_sampling, 1'b1);
         check(o_channel, 5'(k));
         rd(OFS_CONTROL, {1'b0, 5'(k), 2'b01});
         res = expect_res(k[0], code);
         rd(OFS_RES_HIGH, res[15:8]);
         rd(OFS_RES_LOW, res[7:0]);
         rd(OFS_IRQ_STAT, 8'h01);
         check(o_irq, 1'b0);
         wr(OFS_IRQ_MASK, 8'h00);
      end
      // busy without enable is refused at once
      wr(OFS_CONTROL, 8'h02);
      rd(OFS_CONTROL, 8'h00);
      // abort after the guarded window: no load, no event
      wr(OFS_IRQ_MASK, 8'h01);
      wr(OFS_CONTROL, 8'h03);
      repeat (10) @(posedge i_clk);
      wr(OFS_CONTROL, 8'h01);
      repeat (30) @(posedge i_clk);
      check(o_irq, 1'b0);
      rd(OFS_RES_HIGH, res[15:8]);
      wr(OFS_IRQ_MASK, 8'h00);
      @(posedge i_clk) i_soft_rst <= 1'b1;
      @(posedge i_clk) i_soft_rst <= 1'b0;
      rd(OFS_RES_HIGH, res[15:8]);
      rd(OFS_RES_LOW, res[7:0]);
      rd(OFS_CONFIG, 8'h00);
      print_verdict();
   end
endmodule
